/* File: design/dld_dc_load_diag.sv */
// Purpose: Four-channel DC load-diagnostic sequencer with AXI4-Lite.
// Assumes: Converter readings arrive synchronous to i_clk.
// Notes: All channels share one phase sequence and one ramp.
`timescale 1ns/1ps
`default_nettype none
module dld_dc_load_diag
    import dld_pkg::*;
#(
    parameter int SMP_CYC_P = SMP_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [11:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    input wire dld_adc_type [3:0] i_adc,
    output dld_drive_type o_drive,
    output logic o_busy
);
    logic aw_v_q, w_v_q, wr_en, ar_hs;
    logic [7:0] aw_idx_q, ar_idx, wbyte;
    logic [31:0] wdat_q;
    logic wstb_q;
    logic [7:0] ctl_q, time_q, thr_a_q, thr_b_q, chst_q, cst_new, rd_v;
    logic [7:0] flt_a_q, flt_b_q, set_a, set_b;
    logic clr_a, clr_b, map_ok, wr_a, wr_b;
    logic [3:0] req_q, req_set, act_q, pend_q, fails, conf, sw;
    logic [3:0] sup_v, gnd_v, sl_v, ol_v, dry_v;
    logic [11:0] smp_cnt_q;
    logic [2:0] sub_q;
    logic smp_stb, tick;
    logic [3:0] avg_cnt_q;
    logic [13:0] acc_p_q [4];
    logic [13:0] acc_n_q [4];
    logic [9:0] tmr_q, lvl_q, step;
    logic retry_q, paralleled_bridge_output;
    dld_state_type state_q, state_d;
    dld_phase_type phase_q;

    // Ramp increment per tick so the level reaches full scale exactly.
    function automatic logic [9:0] step_of(input int us);
        step_of = 10'(DAC_FS / (us * 1000 / TICK_NS));
    endfunction : step_of

    function automatic logic [9:0] ticks_of(input int us);
        ticks_of = 10'(us * 1000 / TICK_NS);
    endfunction : ticks_of

    function automatic logic [9:0] settle_tk(input logic load,
                                             input logic [7:0] t);
        if (load) begin
            settle_tk = ticks_of(LSET_US[t[LSET_LSB+:2]]);
        end else begin
            settle_tk = ticks_of(SSET_US[t[SSET_LSB+:2]]);
        end
    endfunction : settle_tk

    assign paralleled_bridge_output = ctl_q[CTL_PARALLELED_BRIDGE_OUTPUT];
    assign step = (phase_q == PH_LOAD) ?
        step_of(LRAMP_US[time_q[LRAMP_LSB+:2]]) :
        step_of(SRAMP_US[time_q[SRAMP_LSB+:2]]);

    // Sample strobe and 0.1 ms tick from one divider.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            smp_cnt_q <= 12'h000;
            sub_q <= 3'h0;
        end else if (smp_stb) begin
            smp_cnt_q <= 12'h000;
            sub_q <= 3'(sub_q + 3'h1);
        end else begin
            smp_cnt_q <= 12'(smp_cnt_q + 12'h001);
        end
    end
    assign smp_stb = (smp_cnt_q == 12'(SMP_CYC_P - 1));
    assign tick = smp_stb && (sub_q == 3'(SMP_PER_TICK - 1));

    // AXI4-Lite write path: address and data taken in either order.
    assign wr_en = aw_v_q && w_v_q && !o_s_axi_bvalid;
    assign wbyte = wdat_q[7:0];
    assign wr_a = wr_en && wstb_q && (aw_idx_q == IDX_CHST_A);
    assign wr_b = wr_en && wstb_q && (aw_idx_q == IDX_CHST_B);
    always_comb begin
        unique case (aw_idx_q)
            IDX_CHST_A, IDX_CHST_B, IDX_STAT, IDX_DCTL, IDX_THR_B,
            IDX_TIME, IDX_THR_A, IDX_FLT_A, IDX_FLT_B: map_ok = 1'b1;
            default: map_ok = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            aw_idx_q <= 8'h00;
            wdat_q <= 32'h0000_0000;
            wstb_q <= 1'b0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= RESP_OK;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_v_q <= 1'b1;
                aw_idx_q <= i_s_axi_awaddr[9:2];
                o_s_axi_awready <= 1'b0;
            end else if (!aw_v_q) begin
                o_s_axi_awready <= 1'b1;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_v_q <= 1'b1;
                wdat_q <= i_s_axi_wdata;
                wstb_q <= i_s_axi_wstrb[0];
                o_s_axi_wready <= 1'b0;
            end else if (!w_v_q) begin
                o_s_axi_wready <= 1'b1;
            end
            if (wr_en) begin
                aw_v_q <= 1'b0;
                w_v_q <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= map_ok ? RESP_OK : RESP_ERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-writable configuration.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctl_q <= 8'h00;
            time_q <= TIME_RST;
            thr_a_q <= THR_RST;
            thr_b_q <= THR_RST;
            chst_q <= 8'h00;
        end else if (wr_en && wstb_q) begin
            unique case (aw_idx_q)
                IDX_DCTL: ctl_q <= wbyte;
                IDX_TIME: time_q <= wbyte;
                IDX_THR_A: thr_a_q <= wbyte;
                IDX_THR_B: thr_b_q <= wbyte;
                IDX_CHST_A, IDX_CHST_B: chst_q <= cst_new;
                default: ;
            endcase
        end
    end
    assign cst_new = {wr_b ? wbyte[3:0] : chst_q[7:4],
                      wr_a ? wbyte[3:0] : chst_q[3:0]};

    // Run requests from channel state writes.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_req
            localparam int J = (i % 2 == 0) ? i + 1 : i;
            localparam int THR_LSB = (i % 2 == 0) ? 4 : 0;
            logic [1:0] o, n;
            logic hit;
            logic [9:0] avp, avn, dif, raw, lim;
            logic [3:0] code;
            assign o = chst_q[2*i+:2];
            assign n = cst_new[2*i+:2];
            assign hit = (i < 2) ? wr_a : wr_b;
            assign req_set[i] = hit && ((n == CST_DIAG) ||
                ((o == CST_SLEEP) && (n == CST_MUTE || n == CST_PLAY) &&
                 !ctl_q[CTL_SKIP]));
            // Paired negative pin comes from the next channel.
            assign avp = acc_p_q[i][AVG_SH+:10];
            assign avn = (paralleled_bridge_output && J != i) ? acc_n_q[J][AVG_SH+:10] :
                         acc_n_q[i][AVG_SH+:10];
            assign dif = (avp > avn) ? 10'(avp - avn) : 10'(avn - avp);
            assign raw = (i_adc[i].pos > i_adc[J].neg && paralleled_bridge_output) ?
                10'(i_adc[i].pos - i_adc[J].neg) :
                (paralleled_bridge_output ? 10'(i_adc[J].neg - i_adc[i].pos) :
                 ((i_adc[i].pos > i_adc[i].neg) ?
                  10'(i_adc[i].pos - i_adc[i].neg) :
                  10'(i_adc[i].neg - i_adc[i].pos)));
            assign code = (i >= 2) ? thr_b_q[THR_LSB+:4] : thr_a_q[THR_LSB+:4];
            assign lim = 10'(((code > SL_CODE_MAX ? SL_CODE_MAX : code)
                              + 10'h001) * SL_STEP_CNT);
            assign sup_v[i] = (avp > SUP_THR_CNT) ||
                              (avn > SUP_THR_CNT);
            assign gnd_v[i] = (avp < GND_THR_CNT) ||
                              (avn < GND_THR_CNT);
            assign sl_v[i] = dif < lim;
            assign ol_v[i] = !sl_v[i] && (dif > OL_LIM_CNT);
            assign dry_v[i] = !act_q[i] || (raw < 10'(DIS_CNT));
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    acc_p_q[i] <= 14'h0000;
                    acc_n_q[i] <= 14'h0000;
                end else if (state_q == ST_SETTLE) begin
                    acc_p_q[i] <= 14'h0000;
                    acc_n_q[i] <= 14'h0000;
                end else if (state_q == ST_AVG && smp_stb) begin
                    acc_p_q[i] <= 14'(acc_p_q[i] + 14'(i_adc[i].pos));
                    acc_n_q[i] <= 14'(acc_n_q[i] + 14'(i_adc[i].neg));
                end
            end
        end
    endgenerate

    always_comb begin
        unique case (phase_q)
            PH_SUP: fails = sup_v & act_q;
            PH_GND: fails = gnd_v & act_q;
            default: fails = (sl_v | ol_v) & act_q;
        endcase
    end
    // Only channels failing both trials are confirmed.
    assign conf = retry_q ? (fails & pend_q) : 4'h0;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (req_q != 4'h0) state_d = ST_RAMP;
            ST_RAMP: if (tick && lvl_q >= 10'(DAC_FS - step))
                state_d = ST_SETTLE;
            ST_SETTLE: if (tick && tmr_q <= 10'h001) state_d = ST_AVG;
            ST_AVG: if (smp_stb && avg_cnt_q == 4'(AVG_SMP - 1))
                state_d = ST_RDN;
            ST_RDN: if (tick && lvl_q <= step)
                state_d = (phase_q == PH_LOAD) ? ST_DRAIN : ST_JUDGE;
            ST_DRAIN: if (smp_stb && dry_v == 4'hf) state_d = ST_JUDGE;
            ST_JUDGE: begin
                if (!retry_q && fails != 4'h0) begin
                    state_d = (phase_q == PH_GND) ? ST_WAIT : ST_RAMP;
                end else if (phase_q == PH_LOAD ||
                             (act_q & ~conf) == 4'h0) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_RAMP;
                end
            end
            ST_WAIT: if (tick && tmr_q <= 10'h001) state_d = ST_RAMP;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            phase_q <= PH_SUP;
            act_q <= 4'h0;
            pend_q <= 4'h0;
            retry_q <= 1'b0;
            tmr_q <= 10'h000;
            lvl_q <= 10'h000;
            avg_cnt_q <= 4'h0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && state_d == ST_RAMP) begin
                // All requested channels start together.
                act_q <= paralleled_bridge_output ? {1'b0, req_q[3] | req_q[2],
                                 1'b0, req_q[1] | req_q[0]} : req_q;
                phase_q <= PH_SUP;
                lvl_q <= 10'h000;
            end
            if (state_q == ST_RAMP && tick) begin
                lvl_q <= (state_d == ST_SETTLE) ? 10'(DAC_FS) :
                         10'(lvl_q + step);
                tmr_q <= settle_tk(phase_q == PH_LOAD, time_q);
            end
            if ((state_q == ST_SETTLE || state_q == ST_WAIT) && tick) begin
                tmr_q <= 10'(tmr_q - 10'h001);
            end
            if (state_q == ST_SETTLE) begin
                avg_cnt_q <= 4'h0;
            end else if (state_q == ST_AVG && smp_stb) begin
                avg_cnt_q <= 4'(avg_cnt_q + 4'h1);
            end
            if (state_q == ST_RDN && tick) begin
                lvl_q <= (lvl_q <= step) ? 10'h000 :
                         10'(lvl_q - step);
            end
            if (state_q == ST_JUDGE) begin
                if (!retry_q && fails != 4'h0) begin
                    retry_q <= 1'b1;
                    pend_q <= fails;
                    tmr_q <= 10'(DISCH_TK);
                end else begin
                    retry_q <= 1'b0;
                    act_q <= act_q & ~conf;
                    // Phases strictly in order.
                    phase_q <= (phase_q == PH_SUP) ? PH_GND : PH_LOAD;
                end
            end
        end
    end

    // Requests made while busy wait for the next run.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            req_q <= 4'h0;
        end else if (state_q == ST_IDLE && req_q != 4'h0) begin
            req_q <= req_set;
        end else begin
            req_q <= req_q | req_set;
        end
    end

    // Fault flags: set wins over read-clear.
    assign set_a = {(phase_q == PH_GND && state_q == ST_JUDGE) ? conf : 4'h0,
                    (phase_q == PH_SUP && state_q == ST_JUDGE) ? conf : 4'h0};
    assign set_b = (phase_q == PH_LOAD && state_q == ST_JUDGE) ?
                   {conf & ol_v, conf & sl_v} : 8'h00;
    assign ar_hs = i_s_axi_arvalid && o_s_axi_arready;
    assign ar_idx = i_s_axi_araddr[9:2];
    assign clr_a = ar_hs && ar_idx == IDX_FLT_A;
    assign clr_b = ar_hs && ar_idx == IDX_FLT_B;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flt_a_q <= 8'h00;
            flt_b_q <= 8'h00;
        end else begin
            flt_a_q <= (clr_a ? 8'h00 : flt_a_q) | set_a;
            flt_b_q <= (clr_b ? 8'h00 : flt_b_q) | set_b;
        end
    end

    always_comb begin
        unique case (ar_idx)
            IDX_CHST_A: rd_v = {4'h0, chst_q[3:0]};
            IDX_CHST_B: rd_v = {4'h0, chst_q[7:4]};
            IDX_STAT: rd_v = {act_q, retry_q, phase_q, o_busy};
            IDX_DCTL: rd_v = ctl_q;
            IDX_THR_B: rd_v = thr_b_q;
            IDX_TIME: rd_v = time_q;
            IDX_THR_A: rd_v = thr_a_q;
            IDX_FLT_A: rd_v = flt_a_q;
            IDX_FLT_B: rd_v = flt_b_q;
            default: rd_v = 8'h00;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= RESP_OK;
        end else if (ar_hs) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= {24'h000000, rd_v};
            o_s_axi_rresp <= (ar_idx == IDX_STAT || rd_v != 8'h00 ||
                              ar_idx == IDX_FLT_A || ar_idx == IDX_FLT_B ||
                              ar_idx == IDX_CHST_A || ar_idx == IDX_CHST_B ||
                              ar_idx == IDX_DCTL || ar_idx == IDX_TIME ||
                              ar_idx == IDX_THR_A || ar_idx == IDX_THR_B) ?
                             RESP_OK : RESP_ERR;
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_arready <= 1'b1;
        end else if (!o_s_axi_rvalid) begin
            o_s_axi_arready <= 1'b1;
        end
    end

    // Switch drive: physical switches follow the paired channels.
    assign sw = paralleled_bridge_output ? {act_q[2], act_q[2], act_q[0], act_q[0]} : act_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_drive <= '0;
            o_busy <= 1'b0;
        end else begin
            o_busy <= state_q != ST_IDLE;
            o_drive.level <= lvl_q;
            o_drive.sup_sink <= (phase_q == PH_SUP &&
                                 state_q != ST_IDLE) ? sw : 4'h0;
            o_drive.gnd_src <= (phase_q == PH_GND &&
                                state_q != ST_IDLE) ? sw : 4'h0;
            o_drive.load_loop <= (phase_q == PH_LOAD &&
                                  state_q != ST_IDLE) ? sw : 4'h0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_gnd_first;
        state_q == ST_JUDGE && phase_q == PH_GND && !retry_q && fails != 0;
    endsequence
    property p_load_sw;
        state_q == ST_RAMP && phase_q == PH_LOAD && act_q != 0 |=>
            o_drive.sup_sink == 0 && o_drive.gnd_src == 0 &&
            o_drive.load_loop != 0;
    endproperty
    a_load_sw: assert property (p_load_sw) else $error("load switches");
    property p_settle;
        state_q == ST_SETTLE && $past(state_q) == ST_RAMP |->
            tmr_q == settle_tk(phase_q == PH_LOAD, time_q);
    endproperty
    a_settle: assert property (p_settle) else $error("settle time");
    property p_avg;
        state_q == ST_AVG ##1 state_q == ST_RDN |->
            $past(avg_cnt_q) == 4'(AVG_SMP - 1) && $past(smp_stb);
    endproperty
    a_avg: assert property (p_avg) else $error("average window");
    property p_lvl;
        lvl_q <= 10'(DAC_FS);
    endproperty
    a_lvl: assert property (p_lvl) else $error("ramp overflow");
    property p_drain;
        state_q == ST_DRAIN ##1 state_q == ST_JUDGE |-> $past(dry_v) == 4'hf;
    endproperty
    a_drain: assert property (p_drain) else $error("drain early");
    property p_drop;
        state_q == ST_JUDGE && conf != 0 |=> (act_q & $past(conf)) == 0;
    endproperty
    a_drop: assert property (p_drop) else $error("channel kept");
    property p_retry;
        state_q == ST_JUDGE && !retry_q && fails != 0 |=>
            retry_q && phase_q == $past(phase_q);
    endproperty
    a_retry: assert property (p_retry) else $error("no rerun");
    property p_disch;
        s_gnd_first |=> state_q == ST_WAIT && tmr_q == 10'(DISCH_TK);
    endproperty
    a_disch: assert property (p_disch) else $error("discharge");
    property p_hold;
        flt_a_q[0] && !clr_a |=> flt_a_q[0];
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
endmodule : dld_dc_load_diag
`default_nettype wire

/* File: design/dld_pkg.sv */
// Purpose: Constants and types for the DC load-diagnostic sequencer.
// Assumes: 20 MHz clock, 10-bit converter with a fixed step per count.
// Notes: Short-load and discharge counts are scaled from the converter step below; the other threshold counts are fixed.
package dld_pkg;
    localparam int CLK_NS = 50;
    localparam int SMP_NS = 12500;
    localparam int TICK_NS = 100000;
    localparam int AVG_NS = 200000;
    localparam int DISCH_US = 52000;
    localparam int SMP_CYC = SMP_NS / CLK_NS;
    localparam int SMP_PER_TICK = TICK_NS / SMP_NS;
    localparam int AVG_SMP = AVG_NS / SMP_NS;
    localparam int AVG_SH = $clog2(AVG_SMP);
    localparam int DISCH_TK = DISCH_US * 1000 / TICK_NS;
    localparam int SRAMP_US [4] = '{5000, 2500, 10000, 15000};
    localparam int SSET_US [4] = '{10000, 1000, 20000, 30000};
    localparam int LRAMP_US [4] = '{10000, 5000, 20000, 15000};
    localparam int LSET_US [4] = '{10000, 5000, 20000, 15000};
    localparam int DAC_FS = 600;
    localparam int ADC_UV_LSB = 1000;
    localparam int LOAD_UA = 10000;
    localparam int SL_STEP_MOHM = 500;
    localparam int SL_STEP_CNT = LOAD_UA * SL_STEP_MOHM / 1000 / ADC_UV_LSB;
    localparam logic [3:0] SL_CODE_MAX = 4'h9;
    localparam int DIS_MV = 10;
    localparam int DIS_CNT = DIS_MV * 1000 / ADC_UV_LSB;
    localparam logic [9:0] OL_LIM_CNT = 10'h384;
    localparam logic [9:0] SUP_THR_CNT = 10'h320;
    localparam logic [9:0] GND_THR_CNT = 10'h064;
    localparam logic [7:0] IDX_CHST_A = 8'h03;
    localparam logic [7:0] IDX_CHST_B = 8'h04;
    localparam logic [7:0] IDX_STAT = 8'h05;
    localparam logic [7:0] IDX_DCTL = 8'hb0;
    localparam logic [7:0] IDX_THR_B = 8'hb1;
    localparam logic [7:0] IDX_TIME = 8'hb2;
    localparam logic [7:0] IDX_THR_A = 8'hb3;
    localparam logic [7:0] IDX_FLT_A = 8'hc0;
    localparam logic [7:0] IDX_FLT_B = 8'hc1;
    localparam int CTL_SKIP = 0;
    localparam int CTL_PARALLELED_BRIDGE_OUTPUT = 1;
    localparam int LRAMP_LSB = 6;
    localparam int LSET_LSB = 4;
    localparam int SRAMP_LSB = 2;
    localparam int SSET_LSB = 0;
    localparam logic [7:0] TIME_RST = 8'hc0;
    localparam logic [7:0] THR_RST = 8'h11;
    localparam logic [1:0] CST_SLEEP = 2'h0;
    localparam logic [1:0] CST_MUTE = 2'h1;
    localparam logic [1:0] CST_PLAY = 2'h2;
    localparam logic [1:0] CST_DIAG = 2'h3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef struct packed {
        logic [9:0] pos;
        logic [9:0] neg;
    } dld_adc_type;
    typedef struct packed {
        logic [3:0] sup_sink;
        logic [3:0] gnd_src;
        logic [3:0] load_loop;
        logic [9:0] level;
    } dld_drive_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_RAMP = 3'b001, ST_SETTLE = 3'b010,
        ST_AVG = 3'b011, ST_RDN = 3'b100, ST_DRAIN = 3'b101,
        ST_JUDGE = 3'b110, ST_WAIT = 3'b111
    } dld_state_type;
    typedef enum logic [1:0] {
        PH_SUP = 2'b00, PH_GND = 2'b01, PH_LOAD = 2'b10
    } dld_phase_type;
endpackage : dld_pkg

/* File: testbench/dld_load_model.sv */
// Purpose: Speaker load on the bridged outputs.
// Assumes: One count per mV; modes 0 good, 1 supply, 2 ground.
// Notes: Modes 3 open and 4 shorted; a good load reads 80 mV.
`timescale 1ns/1ps
`default_nettype none
module dld_load_model import dld_pkg::*; (
    input wire dld_drive_type i_drive,
    input wire logic [3:0][2:0] i_mode,
    output var dld_adc_type [3:0] o_adc
);
    // Open load reads high only while current flows, so drain can end.
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            o_adc[c] = {10'h1f4, 10'h1f4};
            if (i_drive.load_loop[c] && i_drive.level != 0) begin
                case (i_mode[c])
                    3'h0: o_adc[c].pos = 10'h1f4 +
                        10'(32'(i_drive.level) / 15 * 2);
                    3'h3: o_adc[c] = {10'h3e8, 10'h032};
                    default: ;
                endcase
            end
            if (i_mode[c] == 3'h1) o_adc[c] = {10'h3e8, 10'h3e8};
            if (i_mode[c] == 3'h2) o_adc[c] = '0;
        end
    end
endmodule : dld_load_model
`default_nettype wire

/* File: testbench/test_dld_dc_load_diag.sv */
// Purpose: Self-checking bench for the DC load-diagnostic sequencer.
// Assumes: SMP_CYC_P of 4, so one timing tick is 32 cycles.
// Notes: Fault bytes are predicted from the load mode of each channel.
`timescale 1ns/1ps
`default_nettype none
module test_dld_dc_load_diag import dld_pkg::*;;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wrdy, bv, arr, rv, busy;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic [1:0] bresp, rresp;
    logic [3:0][2:0] mode = '0;
    logic [7:0] got, thr, e_c0, e_c1, bad;
    logic [3:0] seen;
    dld_adc_type [3:0] adc;
    dld_drive_type drv;
    int n_errors = 0, n_checks = 0, cyc = 0, seed = 99, q[$];
    dld_dc_load_diag #(.SMP_CYC_P(4)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
        .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
        .o_s_axi_rdata(rd), .o_s_axi_rresp(rresp), .i_adc(adc),
        .o_drive(drv), .o_busy(busy));
    dld_load_model i_load (.i_drive(drv), .i_mode(mode), .o_adc(adc));
    initial forever #25 clk = ~clk;
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // Handshakes are judged 1 ns after an edge, before the next one.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        awv <= 1;
        wv <= 1;
        br <= 1;
        awa <= {2'h0, a, 2'h0};
        wd <= {24'h0, d};
        do begin
            #1;
            ta = awv && awr;
            tw = wv && wrdy;
            tb = bv;
            got = {6'h0, bresp};
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end while (!tb);
        br <= 0;
        @(posedge clk);
        chk(got, {6'h0, RESP_OK});
    endtask : wr
    task automatic rdr(input logic [7:0] a, input logic [7:0] e,
                       input logic [1:0] er);
        logic ta, tr;
        logic [1:0] r2;
        arv <= 1;
        rr <= 1;
        ara <= {2'h0, a, 2'h0};
        do begin
            #1;
            ta = arv && arr;
            tr = rv;
            got = rd[7:0];
            r2 = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
        end while (!tr);
        rr <= 0;
        @(posedge clk);
        chk(got, e);
        chk({6'h0, r2}, {6'h0, er});
    endtask : rdr
    // Waits for 64 idle cycles and records which load switches closed.
    task automatic wait_idle();
        bad = 0;
        seen = 0;
        for (int idle = 0; idle < 64; idle++) begin
            @(posedge clk);
            if (busy !== 1'b0) idle = 0;
            seen = seen | drv.load_loop;
            bad[1] = bad[1] | ((|drv.load_loop) &
                               (|{drv.sup_sink, drv.gnd_src}));
            bad[2] = bad[2] | (drv.level > DAC_FS);
        end
    endtask : wait_idle
    initial begin
        q = '{1, 2, 3, 4};
        e_c0 = 0;
        e_c1 = 0;
        bad = 0;
        foreach (q[c]) begin
            mode[c] = 3'(q[c]);
            if (q[c] == 1) e_c0[c] = 1;
            if (q[c] == 2) e_c0[c + 4] = 1;
            if (q[c] == 3) e_c1[c + 4] = 1;
            if (q[c] == 4) e_c1[c] = 1;
        end
        thr[7:4] = 4'(unsigned'($random(seed)) % 10);
        thr[3:0] = 4'(unsigned'($random(seed)) % 10);
        repeat (5) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        rdr(IDX_TIME, TIME_RST, RESP_OK);
        rdr(IDX_THR_A, THR_RST, RESP_OK);
        rdr(8'hff, 8'h00, RESP_ERR);
        wr(IDX_THR_B, thr);
        rdr(IDX_THR_B, thr, RESP_OK);
        wr(IDX_TIME, 8'h55);
        rdr(IDX_TIME, 8'h55, RESP_OK);
        wr(IDX_CHST_A, {4'h0, CST_DIAG, CST_DIAG});
        wr(IDX_CHST_B, {4'h0, CST_DIAG, CST_DIAG});
        wait_idle();
        chk(bad, 8'h00);
        chk({4'h0, seen}, 8'h0c);
        rdr(IDX_FLT_A, e_c0, RESP_OK);
        rdr(IDX_FLT_B, e_c1, RESP_OK);
        rdr(IDX_FLT_A, 8'h00, RESP_OK);
        // Leaving sleep must not start a run while the skip bit is set.
        wr(IDX_DCTL, 8'h01);
        wr(IDX_CHST_A, {4'h0, CST_SLEEP, CST_SLEEP});
        wr(IDX_CHST_A, {4'h0, CST_MUTE, CST_PLAY});
        repeat (4) @(posedge clk);
        chk({7'h0, busy}, 8'h00);
        mode <= '0;
        wr(IDX_DCTL, 8'h02);
        wr(IDX_CHST_A, {4'h0, CST_SLEEP, CST_SLEEP});
        wr(IDX_CHST_A, {4'h0, CST_MUTE, CST_PLAY});
        repeat (4) @(posedge clk);
        chk({7'h0, busy}, 8'h01);
        wait_idle();
        chk({4'h0, seen}, 8'h03);
        chk(bad, 8'h00);
        rdr(IDX_FLT_A, 8'h00, RESP_OK);
        rdr(IDX_FLT_B, 8'h00, RESP_OK);
        complete_run();
    end
endmodule : test_dld_dc_load_diag
`default_nettype wire
